// ==== pkg/tsr_pkg.sv ====
// constants and types for the temperature schedule and user storage block
// Notes on behaviour
// - low temperature byte is read only; host writes to it change nothing
// - periodic enable is config bit 7, resets to 1, needs request bit 0
// - periodic start every 1,2,4..128 s chosen by config bits 5:3, reset 5
// - each periodic measurement is followed by a divider ratio update
// - host writes 1 to config bit 6 for one measurement plus divider update
// - sixty-four read/write user bytes at addresses 0x22 through 0x61
// - device never holds the serial clock low; it has no clock driver
package tsr_pkg;

  localparam logic [7:0] ADDR_TEMP_LOW   = 8'h1B;
  localparam logic [7:0] ADDR_CONFIG     = 8'h1C;
  localparam logic [7:0] ADDR_RAM_FIRST  = 8'h22;
  localparam logic [7:0] ADDR_RAM_LAST   = 8'h61;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;
  localparam int         RAM_DEPTH       = 64;

  localparam int         CFG_AUTO_BIT    = 7;
  localparam int         CFG_SHOT_BIT    = 6;
  localparam int         CFG_PERIOD_MSB  = 5;
  localparam int         CFG_PERIOD_LSB  = 3;
  localparam logic       CFG_AUTO_RESET  = 1'b1;
  localparam logic       CFG_SHOT_RESET  = 1'b0;
  localparam logic [2:0] CFG_PERIOD_RESET = 3'h5;
  localparam logic [2:0] CFG_LOW_ZERO    = 3'h0;

  // arbitrary default bus address, not tied to any real part
  localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h5A;

  localparam int         CLK_HZ          = 125_000_000;
  localparam int         MEAS_UNIT_S     = 1;
  localparam int         CYCLES_PER_UNIT = MEAS_UNIT_S * CLK_HZ;
  localparam int         UNIT_CNT_W      = 27;
  localparam int         BIT_COUNT_BYTE  = 8;

  typedef enum logic [2:0] {
    TSR_I_IDLE, TSR_I_ADDR, TSR_I_AACK, TSR_I_WBYTE,
    TSR_I_WACK, TSR_I_RBYTE, TSR_I_RACK
  } tsr_i2c_state_t;

  typedef enum logic [0:0] {
    TSR_M_IDLE, TSR_M_BUSY
  } tsr_meas_state_t;

endpackage

// ==== hw/tsr_i2c_slave.sv ====
// serial bus target: address match, register pointer, byte read and write
module tsr_i2c_slave #(
  parameter logic [6:0] BUS_ADDR = tsr_pkg::BUS_ADDR_DEFAULT
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  output logic            wr_en,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data
);
  import tsr_pkg::*;

  typedef struct packed {
    logic [1:0]     scl_s;
    logic [1:0]     sda_s;
    logic           scl_d;
    logic           sda_d;
    tsr_i2c_state_t st;
    logic [3:0]     cnt;
    logic [7:0]     sh;
    logic           rw;
    logic           first;
    logic [7:0]     ptr;
    logic [7:0]     waddr;
    logic [7:0]     wdat;
    logic           wr;
    logic           oe;
  } tsr_i2c_t;

  tsr_i2c_t q;
  tsr_i2c_t next_q;
  logic     rise;
  logic     fall;
  logic     start;
  logic     stop;

  ////////////////////////////////////////////////////////////////////////////
  // only the second sync stage and its delayed copy feed edge logic
  assign rise  = q.scl_s[1] & ~q.scl_d;
  assign fall  = ~q.scl_s[1] & q.scl_d;
  assign start = q.scl_s[1] & q.scl_d & q.sda_d & ~q.sda_s[1];
  assign stop  = q.scl_s[1] & q.scl_d & ~q.sda_d & q.sda_s[1];

  always_comb begin
    next_q       = q;
    next_q.wr    = 1'b0;
    next_q.scl_s = {q.scl_s[0], scl_in};
    next_q.sda_s = {q.sda_s[0], sda_in};
    next_q.scl_d = q.scl_s[1];
    next_q.sda_d = q.sda_s[1];
    if (start) begin
      next_q.st  = TSR_I_ADDR;
      next_q.cnt = 4'h0;
      next_q.oe  = 1'b0;
    end else if (stop) begin
      next_q.st = TSR_I_IDLE;
      next_q.oe = 1'b0;
    end else begin
      unique case (q.st)
        TSR_I_IDLE: begin
        end
        TSR_I_ADDR, TSR_I_WBYTE: begin
          if (rise) begin
            next_q.sh  = {q.sh[6:0], q.sda_s[1]};
            next_q.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == 4'(BIT_COUNT_BYTE)) begin
            if (q.st == TSR_I_ADDR) begin
              if (q.sh[7:1] == BUS_ADDR) begin
                next_q.st    = TSR_I_AACK;
                next_q.oe    = 1'b1;
                next_q.rw    = q.sh[0];
                next_q.first = 1'b1;
              end else begin
                next_q.st = TSR_I_IDLE;
              end
            end else begin
              next_q.st    = TSR_I_WACK;
              next_q.oe    = 1'b1;
              next_q.first = 1'b0;
              if (q.first) begin
                next_q.ptr = q.sh;
              end else begin
                next_q.wr    = 1'b1;
                next_q.waddr = q.ptr;
                next_q.wdat  = q.sh;
                next_q.ptr   = q.ptr + 8'h01;
              end
            end
          end
        end
        TSR_I_AACK, TSR_I_WACK: begin
          if (fall) begin
            next_q.cnt = 4'h0;
            if (q.st == TSR_I_AACK && q.rw) begin
              next_q.st  = TSR_I_RBYTE;
              next_q.sh  = rd_data;
              next_q.oe  = ~rd_data[7];
              next_q.ptr = q.ptr + 8'h01;
            end else begin
              next_q.st = TSR_I_WBYTE;
              next_q.oe = 1'b0;
            end
          end
        end
        TSR_I_RBYTE: begin
          if (fall) begin
            next_q.cnt = q.cnt + 4'h1;
            if (q.cnt == 4'(BIT_COUNT_BYTE - 1)) begin
              next_q.st = TSR_I_RACK;
              next_q.oe = 1'b0;
            end else begin
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.oe = ~q.sh[6];
            end
          end
        end
        TSR_I_RACK: begin
          // a not-acknowledge ends the read; otherwise reload at next fall
          if (rise) begin
            next_q.st = q.sda_s[1] ? TSR_I_IDLE : TSR_I_AACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q       <= '0;
      q.scl_s <= 2'h3;
      q.sda_s <= 2'h3;
      q.scl_d <= 1'b1;
      q.sda_d <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // no clock driver at all, and data only moves while the clock is low
  assign sda_out = 1'b0;
  assign sda_oe  = q.oe;
  assign rd_addr = q.ptr;
  assign wr_en   = q.wr;
  assign wr_addr = q.waddr;
  assign wr_data = q.wdat;

  a_sda_low_phase: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(q.oe) |-> !q.scl_d)
    else $error("data line driven while clock high");

endmodule

// ==== hw/tsr_top.sv ====
// temperature measurement schedule, result byte and user storage registers
module tsr_top #(
  parameter int         CYCLES_PER_UNIT_P = tsr_pkg::CYCLES_PER_UNIT,
  parameter logic [6:0] BUS_ADDR          = tsr_pkg::BUS_ADDR_DEFAULT
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            meas_start,
  input  wire logic       meas_done,
  input  wire logic [7:0] meas_temp_low,
  output logic            div_update
);
  import tsr_pkg::*;

  typedef struct packed {
    logic [7:0]                 temp;
    logic                       auto_en;
    logic                       shot_req;
    logic [2:0]                 period;
    logic [RAM_DEPTH-1:0][7:0]  ram;
    logic [UNIT_CNT_W-1:0]      tick_cnt;
    logic [7:0]                 sec_cnt;
    tsr_meas_state_t            mst;
    logic                       shot_active;
    logic                       start;
    logic                       div;
  } tsr_top_t;

  tsr_top_t   q;
  tsr_top_t   next_q;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] wr_off;
  logic [7:0] rd_off;
  logic [5:0] ram_idx;
  logic       ram_wr;
  logic       cfg_wr;
  logic       tick;
  logic       period_hit;

  tsr_i2c_slave #(
    .BUS_ADDR (BUS_ADDR)
  ) u_bus (
    .clock   (clock),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode
  assign wr_off  = wr_addr - ADDR_RAM_FIRST;
  assign rd_off  = rd_addr - ADDR_RAM_FIRST;
  assign ram_idx = wr_off[5:0];
  assign ram_wr  = wr_en && wr_addr >= ADDR_RAM_FIRST
                   && wr_addr <= ADDR_RAM_LAST;
  assign cfg_wr  = wr_en && wr_addr == ADDR_CONFIG;

  // read mux is combinational so the bus side loads a byte in one cycle
  assign rd_data =
    (rd_addr == ADDR_TEMP_LOW) ? q.temp :
    (rd_addr == ADDR_CONFIG)   ? {q.auto_en, q.shot_req, q.period,
                                  CFG_LOW_ZERO} :
    (rd_addr >= ADDR_RAM_FIRST && rd_addr <= ADDR_RAM_LAST)
                               ? q.ram[rd_off[5:0]] : READ_UNMAPPED;

  ////////////////////////////////////////////////////////////////////////////
  // one-second base tick and interval count
  assign tick = q.tick_cnt == UNIT_CNT_W'(CYCLES_PER_UNIT_P - 1);
  assign period_hit = (q.sec_cnt + 8'h01) >= (8'h01 << q.period);

  always_comb begin
    next_q          = q;
    next_q.start    = 1'b0;
    next_q.div      = 1'b0;
    next_q.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
    // saturates at the interval so a late enable fires on the next tick
    if (tick && !period_hit) begin
      next_q.sec_cnt = q.sec_cnt + 8'h01;
    end
    unique case (q.mst)
      TSR_M_IDLE: begin
        if (q.shot_req) begin
          next_q.mst         = TSR_M_BUSY;
          next_q.start       = 1'b1;
          next_q.shot_active = 1'b1;
          next_q.sec_cnt     = 8'h00;
        end else if (q.auto_en && tick && period_hit) begin
          next_q.mst         = TSR_M_BUSY;
          next_q.start       = 1'b1;
          next_q.shot_active = 1'b0;
          next_q.sec_cnt     = 8'h00;
        end
      end
      TSR_M_BUSY: begin
        if (meas_done) begin
          next_q.mst  = TSR_M_IDLE;
          next_q.temp = meas_temp_low;
          next_q.div  = 1'b1;
          if (q.shot_active) begin
            next_q.shot_req = 1'b0;
          end
        end
      end
    endcase
    // host writes come last: a new request wins over the device clear
    if (cfg_wr) begin
      next_q.auto_en = wr_data[CFG_AUTO_BIT];
      next_q.period  = wr_data[CFG_PERIOD_MSB:CFG_PERIOD_LSB];
      if (wr_data[CFG_SHOT_BIT]) begin
        next_q.shot_req = 1'b1;
      end
    end
    if (ram_wr) begin
      next_q.ram[ram_idx] = wr_data;
    end
    // a write to the temperature byte falls through with no effect
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q          <= '0;
      q.auto_en  <= CFG_AUTO_RESET;
      q.shot_req <= CFG_SHOT_RESET;
      q.period   <= CFG_PERIOD_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign meas_start = q.start;
  assign div_update = q.div;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_meas_done;
    q.mst == TSR_M_BUSY && meas_done;
  endsequence

  sequence s_shot_done;
    s_meas_done ##0 q.shot_active && !(cfg_wr && wr_data[CFG_SHOT_BIT]);
  endsequence

  a_temp_readonly: assert property (
    wr_en && wr_addr == ADDR_TEMP_LOW && !(q.mst == TSR_M_BUSY && meas_done)
    |=> $stable(q.temp))
    else $error("temperature byte changed by a host write");

  a_config_reset: assert property (disable iff (1'b0)
    !rst_n |=> q.auto_en && !q.shot_req && q.period == CFG_PERIOD_RESET)
    else $error("configuration reset value wrong");

  a_auto_gated: assert property (
    meas_start && !q.shot_active |-> $past(q.auto_en) && !$past(q.shot_req))
    else $error("periodic start without enable or with request pending");

  a_period_start: assert property (
    q.mst == TSR_M_IDLE && !q.shot_req && q.auto_en && tick && period_hit
    |=> meas_start ##1 !meas_start)
    else $error("periodic start missed at interval");

  a_div_after_meas: assert property (
    s_meas_done |=> div_update && q.temp == $past(meas_temp_low))
    else $error("divider update or result missing after measurement");

  a_shot_start: assert property (
    q.mst == TSR_M_IDLE && q.shot_req |=> meas_start && q.shot_active)
    else $error("single conversion request not started");

  a_shot_clear: assert property (
    s_shot_done |=> !q.shot_req && div_update)
    else $error("request bit not cleared after single conversion");

  a_ram_write: assert property (
    ram_wr |=> q.ram[$past(ram_idx)] == $past(wr_data))
    else $error("user byte not stored");

endmodule

// ==== verif/tsr_host_model.sv ====
// serial bus master model: drives the clock pin and pulls the data pin
module tsr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h5A
) (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack;
  int   nacks = 0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp();
    repeat (10) @(posedge clock);
    #1;
  endtask
  // clock driven push-pull; the device never holds it low
  task automatic clk_bit(output logic b);
    hp();
    scl = 1'b1;
    hp();
    b = sda;
    scl = 1'b0;
    // short hold so data never moves with the falling clock
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic start();
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask
  task automatic send(input logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~d[i];
      clk_bit(b);
    end
    sda_low = 1'b0;
    clk_bit(b);
    ack = ~b;
    if (!ack) nacks++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    send({DEV_ADDR, 1'b0});
    send(a);
    send(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic b;
    start();
    send({DEV_ADDR, 1'b0});
    send(a);
    start();
    send({DEV_ADDR, 1'b1});
    sda_low = 1'b0;
    for (int i = 7; i >= 0; i--) clk_bit(d[i]);
    clk_bit(b);
    stop();
  endtask
endmodule

// ==== verif/tsr_top_tb_top.sv ====
// self-checking bench for the measurement schedule and user storage block
module tsr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tsr_pkg::*;
  localparam int UNIT = 16;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } tsr_row_t;
  tsr_row_t   rows [6] = '{'{8'h22, 8'hA5, 8'hA5}, '{8'h61, 8'h5A, 8'h5A},
                           '{8'h41, 8'hC3, 8'hC3}, '{8'h62, 8'h77, 8'h00},
                           '{8'h21, 8'h11, 8'h00}, '{8'h1C, 8'h17, 8'h10}};
  logic       clock, rst_n, scl, sda_low, sda, sda_out, sda_oe;
  logic       meas_start, meas_done, div_update, done_q;
  logic [7:0] meas_temp_low, temp_val, rd;
  int         failures = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         n_start = 0;
  int         t_start = 0;
  int         t_prev = 0;
  int         n;
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  tsr_top #(.CYCLES_PER_UNIT_P(UNIT)) u_dut (
    .clock, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .meas_start, .meas_done, .meas_temp_low, .div_update
  );
  tsr_host_model u_host (.clock, .sda, .scl, .sda_low);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_start();
    int m = n_start;
    for (int i = 0; i < 3000 && n_start == m; i++) @(posedge clock);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // sensor: answers each start three cycles later; data is junk otherwise
  initial begin
    meas_done = 1'b0;
    meas_temp_low = 8'hFF;
    temp_val = 8'h00;
    forever begin
      @(posedge clock);
      if (meas_start) begin
        repeat (3) @(posedge clock);
        #1;
        temp_val += 8'h40;
        meas_done = 1'b1;
        meas_temp_low = temp_val;
        @(posedge clock);
        #1;
        meas_done = 1'b0;
        meas_temp_low = ~temp_val;
      end
    end
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    done_q <= meas_done;
    if (rst_n) check(div_update, done_q);
    if (meas_start) begin
      n_start <= n_start + 1;
      t_prev <= t_start;
      t_start <= cyc;
    end
    if (cyc == 80000) begin
      failures++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    u_host.rd(ADDR_CONFIG, rd);
    check(rd, 8'hA8);
    $display("test reset done");
    foreach (rows[i]) begin
      u_host.wr(rows[i].addr, rows[i].wdata);
      u_host.rd(rows[i].addr, rd);
      check(rd, rows[i].exp);
    end
    $display("test table done");
    for (int p = 0; p < 8; p++) begin
      u_host.wr(ADDR_CONFIG, {2'b10, 3'(p), 3'h0});
      wait_start();
      wait_start();
      check(t_start - t_prev, UNIT << p);
    end
    $display("test periodic done");
    u_host.wr(ADDR_CONFIG, 8'h00);
    n = n_start;
    repeat (600) @(posedge clock);
    check(n_start - n, 0);
    // host asks for one conversion, then reads the request bit back once
    u_host.wr(ADDR_CONFIG, 8'h40);
    u_host.rd(ADDR_CONFIG, rd);
    check(rd, 8'h00);
    check(n_start - n, 1);
    u_host.wr(ADDR_TEMP_LOW, ~temp_val);
    u_host.rd(ADDR_TEMP_LOW, rd);
    check(rd, temp_val);
    $display("test single conversion done");
    check(u_host.nacks, 0);
    u_host.start();
    u_host.send({~BUS_ADDR_DEFAULT, 1'b0});
    u_host.stop();
    check(u_host.ack, 1'b0);
    $display("test wrong address done");
    // reset again in mid-run: config and user bytes return to reset values
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    u_host.rd(ADDR_CONFIG, rd);
    check(rd, 8'hA8);
    u_host.rd(ADDR_RAM_FIRST, rd);
    check(rd, 8'h00);
    $display("test mid-run reset done");
    final_report();
  end
endmodule
